/* hdl/sensor_fault_diagnosis.sv */
// fault collection, self-test sequencing and link diagnostics
//
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module sensor_fault_diagnosis #(
    parameter int CYC_PERIOD = sensor_diag_pkg::CYC_PERIOD_CYC
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // fault detectors, levels
    input  wire logic        sensor_fault_high_side,
    input  wire logic        sensor_fault_low_side,
    input  wire logic        excitation_short_fault,
    input  wire logic        high_supply_fault,
    input  wire logic        internal_supply_fault,
    input  wire logic        amplifier_saturation,
    input  wire logic        signal_converter_overrange,
    input  wire logic        temp_converter_overrange,
    input  wire logic        temp_norm_saturation,
    input  wire logic        correction_saturation,
    input  wire logic        output_driver_fault,
    input  wire logic        nvm_correction_fault,
    input  wire logic        control_flow_fault,
    input  wire logic        ground_loss,
    input  wire logic        supply_loss,
    input  wire logic        oscillator_fail,
    // self-test engines
    output logic [5:0]       test_start,
    input  wire logic [5:0]  test_done,
    input  wire logic [5:0]  test_fail,
    // link and system outputs
    output logic             driver_enable,
    output logic             operation_halt,
    output logic             processor_reset,
    output logic             init_fault,
    output logic             status_error_flag,
    output logic             fast_override,
    output logic [11:0]      fast_value,
    output logic [11:0]      slow_channel_diag_code
);
    // position of a test's failure bit in the status word
    function automatic int fail_pos(input int i);
        fail_pos = (i == sensor_diag_pkg::T_CROM) ? 13 : 8 + i;
    endfunction : fail_pos

    typedef enum logic [2:0] {
        st_logic, st_rom, st_ram, st_nvm, st_run
    } post_e;

    post_e       state_q;
    logic        started_q;
    logic [15:0] err_q;
    logic [15:0] ena_q;
    logic [15:0] stat_q;
    logic [1:0]  mode_q;
    logic        nvm_post_q;
    logic        post_done_q;
    logic [31:0] cyc_cnt_q;
    logic        wr_pend_q;
    logic [7:0]  wr_idx_q;

    // bus decode
    wire         addr_ph = hsel & hready & htrans[1];
    wire  [7:0]  a_idx   = haddr[9:2];
    wire         wr_err  = wr_pend_q & (wr_idx_q == sensor_diag_pkg::IDX_ERR);
    wire         wr_stat = wr_pend_q & (wr_idx_q == sensor_diag_pkg::IDX_STAT);
    wire         wr_ena  = wr_pend_q & (wr_idx_q == sensor_diag_pkg::IDX_ENA);
    wire         wr_ctrl = wr_pend_q & (wr_idx_q == sensor_diag_pkg::IDX_CTRL);

    // mode and halt decode
    wire oper   = (mode_q == sensor_diag_pkg::MODE_OPER);
    wire cfgdg  = (mode_q == sensor_diag_pkg::MODE_CFG)
                | (mode_q == sensor_diag_pkg::MODE_DIAG);
    wire halt   = ground_loss | supply_loss | oscillator_fail;
    wire cyc_dis = ena_q[sensor_diag_pkg::E_CYCDIS];

    // live detectors into error word positions
    wire [15:0] det;
    assign det[sensor_diag_pkg::E_SIG]    = 1'b0;
    assign det[sensor_diag_pkg::E_V3]     = internal_supply_fault;
    assign det[sensor_diag_pkg::E_SAMP]   = amplifier_saturation;
    assign det[sensor_diag_pkg::E_SADC]   = signal_converter_overrange;
    assign det[sensor_diag_pkg::E_TADC]   = temp_converter_overrange;
    assign det[sensor_diag_pkg::E_TNORM]  = temp_norm_saturation;
    assign det[sensor_diag_pkg::E_CORR]   = correction_saturation;
    assign det[sensor_diag_pkg::E_DRV]    = output_driver_fault;
    assign det[sensor_diag_pkg::E_EXC]    = excitation_short_fault;
    assign det[sensor_diag_pkg::E_LOW]    = sensor_fault_low_side;
    assign det[sensor_diag_pkg::E_HIGH]   = sensor_fault_high_side;
    assign det[sensor_diag_pkg::E_ECC]    = nvm_correction_fault;
    assign det[sensor_diag_pkg::E_ARITH]  = 1'b0;
    assign det[sensor_diag_pkg::E_V5]     = high_supply_fault;
    assign det[sensor_diag_pkg::E_LCC]    = control_flow_fault;
    assign det[sensor_diag_pkg::E_CYCDIS] = 1'b0;

    // finished tests and failures
    wire [5:0] fin  = test_done;
    wire [5:0] fail = test_done & test_fail;

    // status word set terms
    wire  [15:0] stat_set;
    genvar gi;
    generate
        for (gi = 0; gi < sensor_diag_pkg::NTEST; gi++) begin : g_stat
            assign stat_set[gi] = fin[gi];
            assign stat_set[fail_pos(gi)] = fail[gi];
        end
    endgenerate
    assign stat_set[7:6]   = 2'h0;
    assign stat_set[15:14] = 2'h0;

    // error word set terms; test failures feed bits 0 and 12
    wire [15:0] err_set = det
        | ({15'h0, fail[sensor_diag_pkg::T_CROM]
                 | fail[sensor_diag_pkg::T_NVM]})
        | ({3'h0, fail[sensor_diag_pkg::T_ARITH], 12'h0});

    // clear by writing ones; a set in the same cycle wins
    wire [15:0] err_clr  = wr_err ? (hwdata[15:0]
                         & sensor_diag_pkg::ERR_CLR) : 16'h0;
    wire [15:0] stat_clr = wr_stat ? (hwdata[15:0]
                         & sensor_diag_pkg::STAT_CLR) : 16'h0;
    wire [15:0] err_d  = (err_q & ~err_clr) | err_set;
    wire [15:0] stat_d = (stat_q & ~stat_clr) | stat_set;

    // enabled faults; memory, ecc and flow bits carry no enable
    wire [15:0] mask_en = ((ena_q & ~sensor_diag_pkg::POST_BITS)
                        | sensor_diag_pkg::POST_BITS) & 16'h7fff;
    wire [15:0] masked  = err_q & mask_en;

    // slow channel code selection by priority
    function automatic logic [11:0] dec_sel(
        input logic [15:0] m,
        input logic        post_nvm,
        input logic        cyc_nvm,
        input logic        crom
    );
        logic [7:0] grp;
        grp = {m[7:1], crom};
        if (post_nvm)
            dec_sel = sensor_diag_pkg::DEC_NVM_POST;
        else if (m[sensor_diag_pkg::E_EXC])
            dec_sel = sensor_diag_pkg::DEC_EXC_SHORT;
        else if (m[sensor_diag_pkg::E_LOW] | m[sensor_diag_pkg::E_HIGH])
            dec_sel = sensor_diag_pkg::DEC_SENSOR;
        else if (cyc_nvm)
            dec_sel = sensor_diag_pkg::DEC_NVM_CYC;
        else if (m[sensor_diag_pkg::E_ARITH])
            dec_sel = sensor_diag_pkg::DEC_ARITH;
        else if (|grp)
            dec_sel = {sensor_diag_pkg::DEC_GROUP, grp};
        else
            dec_sel = sensor_diag_pkg::DEC_NONE;
    endfunction : dec_sel

    // link indications; fault and diagnosis codes only in operational mode
    wire nvm_fail = stat_q[fail_pos(sensor_diag_pkg::T_NVM)];
    wire crom_fail = stat_q[fail_pos(sensor_diag_pkg::T_CROM)];
    wire post_nvm = nvm_post_q & nvm_fail;
    wire cyc_nvm  = nvm_fail & ~nvm_post_q & masked[0];
    wire fc_err   = oper & ((|(masked & sensor_diag_pkg::FC_BITS))
                  | post_nvm);
    wire [11:0] dec_d = oper ? dec_sel(masked, post_nvm, cyc_nvm,
                        crom_fail & masked[0]) : sensor_diag_pkg::DEC_NONE;
    wire hv_off = oper & high_supply_fault
                & ena_q[sensor_diag_pkg::E_V5];
    wire drv_d  = ~halt & post_done_q & ~hv_off;

    // power-on sequencer test selection
    function automatic int st_test(input post_e s);
        case (s)
            st_logic: st_test = sensor_diag_pkg::T_LOGIC;
            st_rom:   st_test = sensor_diag_pkg::T_ROM;
            st_ram:   st_test = sensor_diag_pkg::T_RAM;
            default:  st_test = sensor_diag_pkg::T_NVM;
        endcase
    endfunction : st_test

    wire cur_en = (state_q == st_logic) ? ena_q[sensor_diag_pkg::P_LOGIC]
                : (state_q == st_rom)   ? ena_q[sensor_diag_pkg::P_ROM]
                : (state_q == st_ram)   ? ena_q[sensor_diag_pkg::P_RAM]
                : 1'b1;
    wire cur_done = started_q & fin[st_test(state_q)];
    wire cur_fail = started_q & fail[st_test(state_q)];
    wire in_post  = (state_q != st_run);
    wire post_reset = in_post & cur_fail
                    & (state_q != st_nvm);

    // next sequencer state
    post_e state_d;
    always_comb begin
        state_d = state_q;
        if (control_flow_fault)
            state_d = st_run;
        else if (in_post & ~halt & ((cur_done & ~post_reset) | ~cur_en)) begin
            case (state_q)
                st_logic: state_d = st_rom;
                st_rom:   state_d = st_ram;
                st_ram:   state_d = st_nvm;
                default:  state_d = st_run;
            endcase
        end else if (post_reset)
            state_d = st_logic;
    end

    // start pulses from sequencer, command and cyclic tick
    wire cyc_tick = (cyc_cnt_q == 32'(CYC_PERIOD - 1));
    wire post_go  = in_post & cur_en & ~started_q & ~control_flow_fault;
    wire [5:0] post_start = post_go ? 6'(1 << st_test(state_q)) : 6'h0;
    wire [5:0] cmd_start  = (wr_ctrl & cfgdg & ~in_post)
        ? (hwdata[sensor_diag_pkg::C_CMD +: 6]
           & sensor_diag_pkg::CMD_TESTS) : 6'h0;
    wire [5:0] cyc_start  = (cyc_tick & oper & ~cyc_dis & ~in_post)
        ? sensor_diag_pkg::CYC_TESTS : 6'h0;
    wire [5:0] start_d = halt ? 6'h0
                       : (post_start | cmd_start | cyc_start);

    // register read mux
    wire [31:0] link_word = {1'b0, post_done_q, halt, drv_d,
                             fc_err ? sensor_diag_pkg::FC_ERROR : 12'h0,
                             4'h0, dec_d};
    wire [31:0] rd_d =
        (a_idx == sensor_diag_pkg::IDX_ERR)    ? {16'h0, err_q}
      : (a_idx == sensor_diag_pkg::IDX_ENA)    ? {16'h0, ena_q}
      : (a_idx == sensor_diag_pkg::IDX_MASKED) ? {16'h0, masked}
      : (a_idx == sensor_diag_pkg::IDX_STAT)   ? {16'h0, stat_q}
      : (a_idx == sensor_diag_pkg::IDX_CTRL)   ? {30'h0, mode_q}
      : (a_idx == sensor_diag_pkg::IDX_LINK)   ? link_word
      : 32'h0;

    // bus slave: zero wait states, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0;
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_q <= addr_ph & hwrite;
            if (addr_ph) begin
                wr_idx_q <= a_idx;
                hrdata   <= hwrite ? 32'h0 : rd_d;
            end
        end
    end

    // diagnosis words
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_q  <= sensor_diag_pkg::ERR_RST;
            stat_q <= sensor_diag_pkg::STAT_RST;
            ena_q  <= sensor_diag_pkg::ENA_RST;
            mode_q <= sensor_diag_pkg::MODE_RST;
        end else begin
            err_q  <= err_d;
            stat_q <= stat_d;
            if (wr_ena)
                ena_q <= hwdata[15:0];
            if (wr_ctrl)
                mode_q <= hwdata[sensor_diag_pkg::C_MODE +: 2];
        end
    end

    // power-on sequencer and cyclic divider
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q     <= st_logic;
            started_q   <= 1'b0;
            post_done_q <= 1'b0;
            nvm_post_q  <= 1'b0;
            cyc_cnt_q   <= 32'h0;
        end else begin
            state_q     <= state_d;
            started_q   <= (state_d == state_q) & ~post_reset
                         & (started_q | post_go) & ~cur_done;
            post_done_q <= (state_d == st_run);
            if (state_q == st_nvm & cur_fail)
                nvm_post_q <= 1'b1;
            else if (~stat_d[fail_pos(sensor_diag_pkg::T_NVM)])
                nvm_post_q <= 1'b0;
            cyc_cnt_q <= (cyc_tick | halt) ? 32'h0 : cyc_cnt_q + 32'h1;
        end
    end

    // registered outputs toward the link and system
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            test_start             <= 6'h0;
            driver_enable          <= 1'b0;
            operation_halt         <= 1'b0;
            processor_reset        <= 1'b0;
            init_fault             <= 1'b0;
            status_error_flag      <= 1'b0;
            fast_override          <= 1'b0;
            fast_value             <= 12'h0;
            slow_channel_diag_code <= sensor_diag_pkg::DEC_NONE;
        end else begin
            test_start      <= start_d;
            driver_enable   <= drv_d;
            operation_halt  <= halt;
            processor_reset <= post_reset
                             | control_flow_fault;
            init_fault      <= err_d[sensor_diag_pkg::E_LCC];
            status_error_flag <= |masked;
            fast_override   <= fc_err;
            fast_value      <= fc_err ? sensor_diag_pkg::FC_ERROR : 12'h0;
            slow_channel_diag_code <= dec_d;
        end
    end
endmodule : sensor_fault_diagnosis
`default_nettype wire

/* hdl/sensor_diag_pkg.sv */
// constants for the sensor fault diagnosis block
`default_nettype none
package sensor_diag_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_MASKED = 8'h62;
    localparam logic [7:0] IDX_ERR    = 8'h64;
    localparam logic [7:0] IDX_STAT   = 8'h66;
    localparam logic [7:0] IDX_CTRL   = 8'h70;
    localparam logic [7:0] IDX_LINK   = 8'h72;
    localparam logic [7:0] IDX_ENA    = 8'h74;
    // error code word bit positions
    localparam int E_SIG    = 0;
    localparam int E_V3     = 1;
    localparam int E_SAMP   = 2;
    localparam int E_SADC   = 3;
    localparam int E_TADC   = 4;
    localparam int E_TNORM  = 5;
    localparam int E_CORR   = 6;
    localparam int E_DRV    = 7;
    localparam int E_EXC    = 8;
    localparam int E_LOW    = 9;
    localparam int E_HIGH   = 10;
    localparam int E_ECC    = 11;
    localparam int E_ARITH  = 12;
    localparam int E_V5     = 13;
    localparam int E_LCC    = 14;
    localparam int E_CYCDIS = 15;
    // enable word bits used as power-on test enables
    localparam int P_LOGIC = 0;
    localparam int P_ROM   = 11;
    localparam int P_RAM   = 14;
    localparam logic [15:0] POST_BITS = 16'h4801;
    localparam logic [15:0] FC_BITS   = 16'h17ff;
    // self-test indices; done at bit i, failure at fail_pos(i)
    localparam int T_LOGIC = 0;
    localparam int T_ROM   = 1;
    localparam int T_RAM   = 2;
    localparam int T_NVM   = 3;
    localparam int T_ARITH = 4;
    localparam int T_CROM  = 5;
    localparam int NTEST   = 6;
    localparam logic [5:0] CMD_TESTS = 6'h1f;
    localparam logic [5:0] CYC_TESTS = 6'h38;
    // status and error word bits writable to clear
    localparam logic [15:0] STAT_CLR = 16'h3f3f;
    localparam logic [15:0] ERR_CLR  = 16'h7fff;
    // control word fields
    localparam int C_MODE = 0;
    localparam int C_CMD  = 2;
    localparam logic [1:0] MODE_CFG  = 2'h0;
    localparam logic [1:0] MODE_DIAG = 2'h1;
    localparam logic [1:0] MODE_OPER = 2'h2;
    // reset values
    localparam logic [15:0] ERR_RST  = 16'h0000;
    localparam logic [15:0] ENA_RST  = 16'h0000;
    localparam logic [15:0] STAT_RST = 16'h0000;
    localparam logic [1:0]  MODE_RST = 2'h0;
    // link codes
    localparam logic [11:0] FC_ERROR      = 12'hffa;
    localparam logic [11:0] DEC_EXC_SHORT = 12'ha00;
    localparam logic [11:0] DEC_SENSOR    = 12'ha01;
    localparam logic [11:0] DEC_NVM_CYC   = 12'ha02;
    localparam logic [11:0] DEC_ARITH     = 12'ha03;
    localparam logic [11:0] DEC_NVM_POST  = 12'h003;
    localparam logic [3:0]  DEC_GROUP     = 4'hf;
    localparam logic [11:0] DEC_NONE      = 12'h000;
    // cyclic test period
    localparam int CLK_MHZ       = 250;
    localparam int CYC_PERIOD_US = 1000;
    localparam int CYC_PERIOD_CYC = CYC_PERIOD_US * CLK_MHZ;
endpackage : sensor_diag_pkg
`default_nettype wire

/* dv/selftest_model.sv */
// self-test engine model answering each start with one done pulse
`timescale 1ns/100ps
`default_nettype none
module selftest_model (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // handshake with the block
    input  wire logic [5:0] test_start,
    output logic      [5:0] test_done,
    output logic      [5:0] test_fail,
    // scenario control
    input  wire logic [5:0] fail_mask,
    input  wire logic       slow
);
    logic [3:0] wait_q [6];
    logic       junk_q;
    // count down from a start, then report; slow engines take longer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            test_done <= 6'h00;
            junk_q    <= 1'b0;
            for (int i = 0; i < 6; i++) wait_q[i] <= 4'h0;
        end else begin
            junk_q <= ~junk_q;
            for (int i = 0; i < 6; i++) begin
                test_done[i] <= (wait_q[i] == 4'h1);
                if (test_start[i]) wait_q[i] <= slow ? 4'h9 : 4'h1;
                else if (wait_q[i] != 4'h0) wait_q[i] <= wait_q[i] - 4'h1;
            end
        end
    end
    // the fail level means nothing away from done, so it toggles there
    always_comb
        for (int i = 0; i < 6; i++)
            test_fail[i] = test_done[i] ? fail_mask[i] : junk_q;
endmodule : selftest_model
`default_nettype wire

/* dv/sensor_diag_checker.sv */
// assertion checker bound to the sensor fault diagnosis block
`timescale 1ns/100ps
`default_nettype none
module sensor_diag_checker (
    // clock, reset and bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // detector inputs
    input wire logic        ground_loss,
    input wire logic        supply_loss,
    input wire logic        oscillator_fail,
    input wire logic        control_flow_fault,
    input wire logic        nvm_correction_fault,
    // outputs
    input wire logic [5:0]  test_start,
    input wire logic        driver_enable,
    input wire logic        operation_halt,
    input wire logic        processor_reset,
    input wire logic        init_fault,
    input wire logic        status_error_flag,
    input wire logic        fast_override,
    input wire logic [11:0] fast_value
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       halt_in;
    logic       wr_go;
    logic [2:0] wr_age_q;
    // loss of ground, supply or clock, and an accepted write
    assign halt_in = ground_loss | supply_loss | oscillator_fail;
    assign wr_go   = hsel & hready & htrans[1] & hwrite;
    // cycles since the last accepted write, saturating at seven
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wr_age_q <= 3'h7;
        else if (wr_go) wr_age_q <= 3'h0;
        else if (wr_age_q != 3'h7) wr_age_q <= wr_age_q + 3'h1;
    end
    sequence s_halt_held;
        halt_in [*3];
    endsequence
    sequence s_lcc_answer;
        ##[1:2] processor_reset ##[0:2] init_fault;
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    a_halt_flag: assert property (halt_in |=> operation_halt)
        else $error("halt not raised on loss");
    a_halt_outputs: assert property
        (s_halt_held |-> operation_halt && !driver_enable)
        else $error("driver still enabled during loss");
    a_lcc_answer: assert property
        (control_flow_fault |-> s_lcc_answer)
        else $error("control flow fault not answered");
    a_flag_sticky: assert property
        ($fell(init_fault) |-> wr_age_q <= 3'h4)
        else $error("fault flag dropped without a write");
    a_flag_masked: assert property
        (init_fault ##1 init_fault |-> status_error_flag)
        else $error("status flag missing for unmasked bit");
    a_ecc_flag: assert property
        (nvm_correction_fault |-> ##[1:3] status_error_flag)
        else $error("correction fault not flagged");
    a_fast_value: assert property
        (fast_value == (fast_override ? 12'hffa : 12'h000))
        else $error("fast value wrong");
    a_start_single: assert property
        (|test_start |=> test_start == 6'h00)
        else $error("test start longer than one cycle");
endmodule : sensor_diag_checker
bind sensor_fault_diagnosis sensor_diag_checker sensor_diag_checker_i (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .ground_loss, .supply_loss, .oscillator_fail, .control_flow_fault,
    .nvm_correction_fault, .test_start, .driver_enable, .operation_halt,
    .processor_reset, .init_fault, .status_error_flag, .fast_override,
    .fast_value
);
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the sensor fault diagnosis block
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        hclk, hresetn, hsel, hwrite, slow;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, rd, r, seed;
    logic [14:0] flt;
    logic [2:0]  loss;
    logic [5:0]  fail_mask, test_start, test_done, test_fail;
    logic        hreadyout, hresp, driver_enable, operation_halt;
    logic        processor_reset, init_fault, status_error_flag;
    logic        fast_override;
    logic [31:0] hrdata;
    logic [11:0] fast_value, slow_channel_diag_code;
    int          mismatches, check_count;
    sensor_fault_diagnosis #(.CYC_PERIOD(16)) sensor_fault_diagnosis_i (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .sensor_fault_high_side(flt[10]), .sensor_fault_low_side(flt[9]),
        .excitation_short_fault(flt[8]), .high_supply_fault(flt[13]),
        .internal_supply_fault(flt[1]), .amplifier_saturation(flt[2]),
        .signal_converter_overrange(flt[3]),
        .temp_converter_overrange(flt[4]),
        .temp_norm_saturation(flt[5]), .correction_saturation(flt[6]),
        .output_driver_fault(flt[7]), .nvm_correction_fault(flt[11]),
        .control_flow_fault(flt[14]), .ground_loss(loss[0]),
        .supply_loss(loss[1]), .oscillator_fail(loss[2]), .test_start,
        .test_done, .test_fail, .driver_enable, .operation_halt,
        .processor_reset, .init_fault, .status_error_flag, .fast_override,
        .fast_value, .slow_channel_diag_code);
    selftest_model selftest_model_i (.hclk, .hresetn, .test_start,
        .test_done, .test_fail, .fail_mask, .slow);
    // clock at 250 MHz
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // expected link code for one detector at error bit b
    function automatic logic [31:0] exp_code(input int b, input int en);
        if (en == 0 || b > 10) return 32'h0;
        if (b == 8) return 32'ha00;
        if (b > 8) return 32'ha01;
        return {20'h0, 4'hf, 8'h01 << b};
    endfunction : exp_code
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one single-word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {22'h0, idx, 2'h0};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : bus
    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask : rchk
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (40) @(posedge hclk);
    endtask : do_reset
    task automatic complete_run();
        if (mismatches == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    // watchdog cuts a hang short
    initial begin
        #200000;
        mismatches++;
        complete_run();
    end
    // main sequence
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, flt, loss} = '0;
        {fail_mask, slow, hresetn} = '0;
        seed = 32'he86712ac;
        do_reset();
        rchk(8'h64, 32'h0);
        rchk(8'h10, 32'h0);
        rchk(8'h66, 32'h8);
        r = rnd();
        bus(1'b1, 8'h74, r);
        rchk(8'h74, r & 32'hffff);
        bus(1'b1, 8'h74, 32'h0);
        bus(1'b1, 8'h66, 32'h3f3f);
        for (int i = 0; i < 5; i++) begin
            r = rnd();
            slow <= r[0];
            fail_mask <= 6'h01 << i;
            bus(1'b1, 8'h70, 32'h4 << i);
            repeat (20) @(posedge hclk);
            rchk(8'h66, 32'h101 << i);
            rchk(8'h64, i == 4 ? 32'h1000 : 32'(i == 3));
            bus(1'b1, 8'h66, 32'h3f3f);
            bus(1'b1, 8'h64, 32'h7fff);
        end
        fail_mask <= 6'h00;
        bus(1'b1, 8'h70, 32'h2);
        for (int e = 1; e >= 0; e--) begin
            bus(1'b1, 8'h74, e ? 32'h37fe : 32'h0);
            for (int b = 1; b < 15; b++) begin
                if (b == 12) continue;
                r = rnd();
                flt <= 15'h1 << b;
                repeat (5 + r[2:0]) @(posedge hclk);
                chk(32'(slow_channel_diag_code), exp_code(b, e));
                chk(32'(fast_value), (e && b < 11) ? 32'hffa : 0);
                chk(32'(driver_enable), 32'(!(e && b == 13)));
                flt <= 15'h0;
                rchk(8'h64, 32'h1 << b);
                bus(1'b1, 8'h64, 32'h1 << b);
                rchk(8'h64, 32'h0);
            end
        end
        fail_mask <= 6'h20;
        repeat (60) @(posedge hclk);
        chk(32'(slow_channel_diag_code), 32'hf01);
        rchk(8'h64, 32'h1);
        fail_mask <= 6'h08;
        bus(1'b1, 8'h66, 32'h3f3f);
        repeat (60) @(posedge hclk);
        chk(32'(slow_channel_diag_code), 32'ha02);
        fail_mask <= 6'h00;
        bus(1'b1, 8'h74, 32'h8000);
        repeat (20) @(posedge hclk);
        bus(1'b1, 8'h66, 32'h3f3f);
        bus(1'b1, 8'h64, 32'h7fff);
        repeat (60) @(posedge hclk);
        rchk(8'h66, 32'h0);
        for (int k = 0; k < 3; k++) begin
            loss <= 3'h1 << k;
            repeat (4) @(posedge hclk);
            chk(32'({operation_halt, driver_enable}), 32'h2);
            loss <= 3'h0;
            repeat (4) @(posedge hclk);
            chk(32'({operation_halt, driver_enable}), 32'h1);
        end
        fail_mask <= 6'h08;
        do_reset();
        fail_mask <= 6'h00;
        bus(1'b1, 8'h70, 32'h2);
        repeat (4) @(posedge hclk);
        chk(32'(slow_channel_diag_code), 32'h003);
        bus(1'b0, 8'h66, 32'h0);
        chk(rd & 32'h808, 32'h808);
        complete_run();
    end
endmodule : tb
`default_nettype wire
